// file: inc/gx_pkg.sv
// Shared constants, types and helpers for the serial GPIO expander
package gx_pkg;

  localparam int          PORT_W    = 8;
  localparam int          PIN_W     = 16;
  localparam int          STRAP_W   = 3;
  // Synchroniser vector layout
  localparam int          SY_SCL    = 0;
  localparam int          SY_SDA    = 1;
  localparam int          SY_STRAP  = 2;
  localparam int          SY_PIN    = 5;
  localparam int          SYNC_W    = 21;
  localparam logic [20:0] SYNC_IDLE = 21'h000003;
  // Cycles after reset before the filter holds real pin levels
  localparam int          SETTLE_W  = 4;
  // Upper four slave address bits, a plain default
  localparam logic [3:0]  SLAVE_ADDR_HI = 4'h4;
  localparam logic        RW_READ   = 1'b1;
  // Command pointer codes
  localparam logic [2:0]  CMD_IN0   = 3'h0;
  localparam logic [2:0]  CMD_IN1   = 3'h1;
  localparam logic [2:0]  CMD_OUT0  = 3'h2;
  localparam logic [2:0]  CMD_OUT1  = 3'h3;
  localparam logic [2:0]  CMD_POL0  = 3'h4;
  localparam logic [2:0]  CMD_POL1  = 3'h5;
  localparam logic [2:0]  CMD_CFG0  = 3'h6;
  localparam logic [2:0]  CMD_CFG1  = 3'h7;
  // Register kind in pointer bits 2:1
  localparam logic [1:0]  KIND_IN   = 2'h0;
  localparam logic [1:0]  KIND_OUT  = 2'h1;
  localparam logic [1:0]  KIND_POL  = 2'h2;
  localparam logic [1:0]  KIND_CFG  = 2'h3;
  // Reset values
  localparam logic [15:0] OUT_RST   = 16'hffff;
  localparam logic [15:0] POL_RST   = 16'h0000;
  localparam logic [15:0] CFG_RST   = 16'hffff;
  // Bit slot numbering within a byte frame
  localparam logic [3:0]  BIT_FIRST = 4'h0;
  localparam logic [3:0]  BIT_LAST  = 4'h7;
  localparam logic [3:0]  BIT_ACK   = 4'h8;

  typedef struct packed {
    logic [7:0] p1;
    logic [7:0] p0;
  } gx_pair_s;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_ADDR  = 6'h02,
    ST_WCMD  = 6'h04,
    ST_WDATA = 6'h08,
    ST_RDATA = 6'h10,
    ST_SKIP  = 6'h20
  } gx_state_e;

  function automatic logic [7:0] gx_half(gx_pair_s v, logic hi);
    return hi ? v.p1 : v.p0;
  endfunction : gx_half

  function automatic gx_pair_s gx_put(gx_pair_s v, logic hi, logic [7:0] b);
    gx_pair_s r;
    r = v;
    if (hi)
      r.p1 = b;
    else
      r.p0 = b;
    return r;
  endfunction : gx_put

  // Register pair partner: pointer toggles within its pair
  function automatic logic [2:0] gx_partner(logic [2:0] p);
    return {p[2:1], ~p[0]};
  endfunction : gx_partner

endpackage : gx_pkg

// file: logic/gx_expander.sv
// Serial-bus 16-bit GPIO expander with change interrupt
`timescale 1ns/1ps
`default_nettype none

// How it works
// - After reset all sixteen pins are undriven inputs until direction is written.
// - Input, output, direction and inversion are 8-bit registers, one per port.
// - Each pin's direction follows its own direction register bit.
// - Inversion bits flip the sensed level returned from the input register.
// - Interrupt line pulled low while any pin differs from its held input state.
// - Reset loads all register defaults and returns the bus machine to idle.
// - Low three slave address bits come from three strap inputs.
// - Last address bit selects transfer direction: one read, zero write.
// - Port pins 0 to 7 map onto bits 0 to 7 of that port's registers.
// - Output pins are push-pull, driven high and low from the output register.
// - Command byte low three bits select one of eight registers; defaults as listed.
// - Input reads give sensed levels whatever the direction; writes to them ignored.
// - Output reads give the written value; output bits do nothing on inputs.
// - Direction one makes a pin high-impedance input, zero a driven output.
module gx_expander
(
  input  wire logic             CLK,
  input  wire logic             RST,
  input  wire logic             SCL,
  input  wire logic             SDA_IN,
  input  wire logic [2:0]       ADDR_STRAP,
  input  wire gx_pkg::gx_pair_s GPIO_IN,
  output var  logic             SDA_OUT,
  output var  logic             SDA_OE,
  output var  logic             INT_N_OUT,
  output var  logic             INT_N_OE,
  output var  gx_pkg::gx_pair_s GPIO_OUT,
  output var  gx_pkg::gx_pair_s GPIO_OE
);
  import gx_pkg::*;

  // Pin, strap and bus-line synchronisers with two-stage agreement filter
  logic [SYNC_W-1:0] s1_reg, s2_reg, s3_reg, flt_reg;
  logic [SYNC_W-1:0] flt_next;

  always_comb
  begin
    flt_next = (~(s2_reg ^ s3_reg) & s2_reg) | ((s2_reg ^ s3_reg) & flt_reg);
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      s1_reg  <= SYNC_IDLE;
      s2_reg  <= SYNC_IDLE;
      s3_reg  <= SYNC_IDLE;
      flt_reg <= SYNC_IDLE;
    end
    else
    begin
      s1_reg  <= {GPIO_IN, ADDR_STRAP, SDA_IN, SCL};
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      flt_reg <= flt_next;
    end
  end

  logic               scl_q, sda_q;
  logic [STRAP_W-1:0] strap_q;
  gx_pair_s           pin_q;
  assign scl_q   = flt_reg[SY_SCL];
  assign sda_q   = flt_reg[SY_SDA];
  assign strap_q = flt_reg[SY_STRAP +: STRAP_W];
  assign pin_q   = gx_pair_s'(flt_reg[SY_PIN +: PIN_W]);

  // Link side: deserialiser on the bus clock, cleared at every start/stop
  logic       clr_reg;
  logic       link_rst;
  logic [3:0] lcnt_reg, lcnt_next;
  logic [7:0] lsh_reg, lsh_next;
  logic [7:0] lbyte_reg, lbyte_next;
  logic       ltog_reg, ltog_next;
  assign link_rst = RST | clr_reg;

  always_comb
  begin
    lcnt_next  = lcnt_reg;
    lsh_next   = lsh_reg;
    lbyte_next = lbyte_reg;
    ltog_next  = ltog_reg;
    if (lcnt_reg == BIT_ACK)
      lcnt_next = BIT_FIRST;
    else
    begin
      lsh_next  = {lsh_reg[6:0], SDA_IN};
      lcnt_next = lcnt_reg + 4'h1;
      if (lcnt_reg == BIT_LAST)
      begin
        lbyte_next = {lsh_reg[6:0], SDA_IN};
        ltog_next  = ~ltog_reg;
      end
    end
  end

  always_ff @(posedge SCL or posedge link_rst)
  begin
    if (link_rst)
    begin
      lcnt_reg <= BIT_FIRST;
      lsh_reg  <= 8'h00;
    end
    else
    begin
      lcnt_reg <= lcnt_next;
      lsh_reg  <= lsh_next;
    end
  end

  // Toggle must survive frame clears, or the far side would miss a byte
  always_ff @(posedge SCL or posedge RST)
  begin
    if (RST)
    begin
      lbyte_reg <= 8'h00;
      ltog_reg  <= 1'b0;
    end
    else
    begin
      lbyte_reg <= lbyte_next;
      ltog_reg  <= ltog_next;
    end
  end

  a_link_byte_tog : assert property (@(posedge SCL) disable iff (link_rst)
    lcnt_reg == BIT_LAST |=> ltog_reg != $past(ltog_reg))
    else $error("byte toggle missing after eighth bit");

  // Bus protocol, register file and data line drive
  gx_state_e  state_reg, state_next;
  logic [2:0] ptr_reg, ptr_next;
  logic [3:0] bitpos_reg, bitpos_next;
  logic       ack_reg, ack_next;
  logic       sda_oe_reg, sda_oe_next;
  logic       clr_next;
  logic       scl_prev_reg, sda_prev_reg;
  logic       tog_s1_reg, tog_s2_reg, tog_seen_reg;
  logic [7:0] rdata_reg, rdata_next;
  gx_pair_s   out_reg, out_next, pol_reg, pol_next, cfg_reg, cfg_next, oe_reg;
  logic [1:0] snap_req;
  logic       start, stop, scl_rise, scl_fall, byte_evt, addr_hit, wr_evt;
  logic [3:0] bp_new;
  gx_pair_s   in_live;
  logic [7:0] live_lo;

  assign start    = scl_q & scl_prev_reg & sda_prev_reg & ~sda_q;
  assign stop     = scl_q & scl_prev_reg & ~sda_prev_reg & sda_q;
  assign scl_rise = scl_q & ~scl_prev_reg;
  assign scl_fall = ~scl_q & scl_prev_reg;
  assign byte_evt = tog_s2_reg ^ tog_seen_reg;
  assign addr_hit = lbyte_reg[7:1] == {SLAVE_ADDR_HI, strap_q};
  assign wr_evt   = byte_evt & (state_reg == ST_WDATA) & ~start & ~stop;
  assign in_live  = pin_q ^ pol_reg;
  assign live_lo  = in_live.p0;
  assign bp_new   = (bitpos_reg == BIT_ACK) ? BIT_FIRST : bitpos_reg + 4'h1;

  function automatic logic [7:0] reg_read(logic [2:0] p);
    unique case (p[2:1])
      KIND_IN:  return gx_half(in_live, p[0]);
      KIND_OUT: return gx_half(out_reg, p[0]);
      KIND_POL: return gx_half(pol_reg, p[0]);
      KIND_CFG: return gx_half(cfg_reg, p[0]);
    endcase
  endfunction : reg_read

  always_comb
  begin
    state_next  = state_reg;
    ptr_next    = ptr_reg;
    bitpos_next = bitpos_reg;
    ack_next    = ack_reg;
    sda_oe_next = sda_oe_reg;
    rdata_next  = rdata_reg;
    out_next    = out_reg;
    pol_next    = pol_reg;
    cfg_next    = cfg_reg;
    snap_req    = 2'b00;
    clr_next    = clr_reg;
    if (start | stop)
      clr_next = 1'b1;
    else if (~scl_q)
      clr_next = 1'b0;
    if (start)
    begin
      state_next  = ST_ADDR;
      bitpos_next = BIT_ACK;
      ack_next    = 1'b0;
      sda_oe_next = 1'b0;
    end
    else if (stop)
    begin
      state_next  = ST_IDLE;
      ack_next    = 1'b0;
      sda_oe_next = 1'b0;
    end
    else
    begin
      if (byte_evt)
      begin
        unique case (state_reg)
          ST_ADDR:
            if (addr_hit)
            begin
              ack_next = 1'b1;
              if (lbyte_reg[0] == RW_READ)
              begin
                state_next = ST_RDATA;
                rdata_next = reg_read(ptr_reg);
                snap_req[ptr_reg[0]] = (ptr_reg[2:1] == KIND_IN);
              end
              else
                state_next = ST_WCMD;
            end
            else
              state_next = ST_SKIP;
          ST_WCMD:
          begin
            ptr_next   = lbyte_reg[2:0];
            ack_next   = 1'b1;
            state_next = ST_WDATA;
          end
          ST_WDATA:
          begin
            unique case (ptr_reg[2:1])
              KIND_OUT: out_next = gx_put(out_reg, ptr_reg[0], lbyte_reg);
              KIND_POL: pol_next = gx_put(pol_reg, ptr_reg[0], lbyte_reg);
              KIND_CFG: cfg_next = gx_put(cfg_reg, ptr_reg[0], lbyte_reg);
              KIND_IN:  ;
            endcase
            ptr_next = gx_partner(ptr_reg);
            ack_next = 1'b1;
          end
          ST_IDLE, ST_RDATA, ST_SKIP: ;
        endcase
      end
      // Master acknowledge after a read byte: continue with the partner register
      if (scl_rise && bitpos_reg == BIT_ACK && state_reg == ST_RDATA && !ack_reg)
      begin
        if (!sda_q)
        begin
          ptr_next   = gx_partner(ptr_reg);
          rdata_next = reg_read(gx_partner(ptr_reg));
          snap_req[~ptr_reg[0]] = (ptr_reg[2:1] == KIND_IN);
        end
        else
          state_next = ST_SKIP;
      end
      // Data line only changes while the clock is low, so no false start/stop
      if (scl_fall)
      begin
        bitpos_next = bp_new;
        if (bp_new == BIT_ACK)
          sda_oe_next = ack_reg;
        else
        begin
          ack_next    = 1'b0;
          sda_oe_next = (state_reg == ST_RDATA) & ~rdata_reg[~bp_new[2:0]];
        end
      end
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      state_reg    <= ST_IDLE;
      ptr_reg      <= CMD_IN0;
      bitpos_reg   <= BIT_ACK;
      ack_reg      <= 1'b0;
      sda_oe_reg   <= 1'b0;
      clr_reg      <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      tog_s1_reg   <= 1'b0;
      tog_s2_reg   <= 1'b0;
      tog_seen_reg <= 1'b0;
      rdata_reg    <= 8'h00;
      out_reg      <= OUT_RST;
      pol_reg      <= POL_RST;
      cfg_reg      <= CFG_RST;
      oe_reg       <= ~CFG_RST;
    end
    else
    begin
      state_reg    <= state_next;
      ptr_reg      <= ptr_next;
      bitpos_reg   <= bitpos_next;
      ack_reg      <= ack_next;
      sda_oe_reg   <= sda_oe_next;
      clr_reg      <= clr_next;
      scl_prev_reg <= scl_q;
      sda_prev_reg <= sda_q;
      tog_s1_reg   <= ltog_reg;
      tog_s2_reg   <= tog_s1_reg;
      tog_seen_reg <= tog_s2_reg;
      rdata_reg    <= rdata_next;
      out_reg      <= out_next;
      pol_reg      <= pol_next;
      cfg_reg      <= cfg_next;
      oe_reg       <= ~cfg_next;
    end
  end

  // Push-pull pins: output value always presented, enable gates it
  assign GPIO_OUT = out_reg;
  assign GPIO_OE  = oe_reg;
  assign SDA_OE   = sda_oe_reg;

  // Change interrupt: snapshot of pin levels at the last input read
  gx_pair_s snap_reg, snap_next;
  logic     armed_reg, int_oe_reg, int_oe_next;
  logic     sda_out_reg, int_out_reg;
  // Snapshot waits for the filter, else idle levels would raise a false interrupt
  logic [SETTLE_W-1:0] settle_reg, settle_next;

  always_comb
  begin
    settle_next = {settle_reg[SETTLE_W-2:0], 1'b1};
    snap_next = armed_reg ? snap_reg : pin_q;
    if (snap_req[0])
      snap_next.p0 = pin_q.p0;
    if (snap_req[1])
      snap_next.p1 = pin_q.p1;
    int_oe_next = armed_reg & (pin_q != snap_next);
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      snap_reg    <= 16'h0000;
      settle_reg  <= {SETTLE_W{1'b0}};
      armed_reg   <= 1'b0;
      int_oe_reg  <= 1'b0;
      sda_out_reg <= 1'b0;
      int_out_reg <= 1'b0;
    end
    else
    begin
      snap_reg    <= snap_next;
      settle_reg  <= settle_next;
      armed_reg   <= settle_reg[SETTLE_W-1];
      int_oe_reg  <= int_oe_next;
      sda_out_reg <= 1'b0;
      int_out_reg <= 1'b0;
    end
  end

  assign SDA_OUT   = sda_out_reg;
  assign INT_N_OUT = int_out_reg;
  assign INT_N_OE  = int_oe_reg;

  a_oe_only_write : assert property (@(posedge CLK) disable iff (RST)
    GPIO_OE != $past(GPIO_OE) |-> $past(wr_evt))
    else $error("pin enable changed without a register write");
  a_oe_tracks_cfg : assert property (@(posedge CLK) disable iff (RST)
    wr_evt && ptr_reg == CMD_CFG1 |=> GPIO_OE.p1 == ~$past(lbyte_reg))
    else $error("direction write not reflected on pin enables");
  a_out_write : assert property (@(posedge CLK) disable iff (RST)
    wr_evt && ptr_reg == CMD_OUT0 |=> GPIO_OUT.p0 == $past(lbyte_reg) ##1 $stable(GPIO_OUT))
    else $error("output register write lost");
  a_input_ignored : assert property (@(posedge CLK) disable iff (RST)
    wr_evt && ptr_reg[2:1] == KIND_IN |=> $stable(out_reg) && $stable(pol_reg) && $stable(cfg_reg))
    else $error("write to input register changed state");
  a_pol_read : assert property (@(posedge CLK) disable iff (RST)
    byte_evt && !start && !stop && state_reg == ST_ADDR && addr_hit && lbyte_reg[0]
      && ptr_reg == CMD_IN0 |=> rdata_reg == $past(live_lo))
    else $error("input read ignores inversion");
  a_addr_miss : assert property (@(posedge CLK) disable iff (RST)
    byte_evt && !start && !stop && state_reg == ST_ADDR && !addr_hit |=> state_reg == ST_SKIP)
    else $error("foreign address accepted");
  a_rw_bit : assert property (@(posedge CLK) disable iff (RST)
    byte_evt && !start && !stop && state_reg == ST_ADDR && addr_hit
      |=> state_reg == ($past(lbyte_reg[0]) ? ST_RDATA : ST_WCMD))
    else $error("direction bit misread");
  a_ack_slot : assert property (@(posedge CLK) disable iff (RST)
    scl_fall && !start && !stop && bitpos_reg == BIT_LAST && ack_reg |=> SDA_OE)
    else $error("acknowledge not driven");
  a_int_raise : assert property (@(posedge CLK) disable iff (RST)
    armed_reg && snap_req == 2'b00 && pin_q != snap_reg |=> INT_N_OE && !INT_N_OUT)
    else $error("interrupt not raised on pin change");
  a_int_release : assert property (@(posedge CLK) disable iff (RST)
    armed_reg && pin_q == snap_reg |=> !INT_N_OE)
    else $error("interrupt held with pins at snapshot");

endmodule : gx_expander

`default_nettype wire

// file: verification/gx_i2c_master.sv
// Behavioural serial-bus master that drives the expander's link
`timescale 1ns/1ps
`default_nettype none
module gx_i2c_master
(
  input  wire logic clk,
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_low
);
  // Quarter periods of 16 ns give a 64 ns link clock drifting against CLK
  localparam int HP = 32;
  localparam int QP = 16;

  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic wt(input int n);
    #(n);
  endtask : wt

  // SDA moves mid-low so no edge coincides with an SCL edge
  task automatic clk_bit(input logic drv, output logic seen);
    wt(QP);
    sda_low = drv;
    wt(QP);
    scl = 1'b1;
    wt(HP);
    seen = sda;
    scl = 1'b0;
  endtask : clk_bit

  task automatic start();
    @(negedge clk);
    wt(QP);
    sda_low = 1'b0;
    wt(QP);
    scl = 1'b1;
    wt(HP);
    sda_low = 1'b1;
    wt(HP);
    scl = 1'b0;
  endtask : start

  task automatic stop();
    wt(QP);
    sda_low = 1'b1;
    wt(QP);
    scl = 1'b1;
    wt(HP);
    sda_low = 1'b0;
    wt(HP);
    // Hand back on a falling edge so bench stimulus stays there
    @(negedge clk);
  endtask : stop

  // Sends b MSB first, then the ninth slot with ackdrv
  task automatic byte_io(input logic [7:0] b, input logic ackdrv,
                         output logic [7:0] r, output logic ak);
    logic x;
    for (int i = 7; i >= 0; i--)
      clk_bit(~b[i], r[i]);
    clk_bit(ackdrv, x);
    ak = ~x;
  endtask : byte_io

  task automatic wr(input logic [6:0] a, input logic [2:0] c, input int n,
                    input logic [7:0] d0, input logic [7:0] d1, output logic ak);
    logic [7:0] r;
    logic       k;
    start();
    byte_io({a, 1'b0}, 1'b0, r, ak);
    byte_io({5'h00, c}, 1'b0, r, k);
    ak = ak & k;
    if (n > 0)
    begin
      byte_io(d0, 1'b0, r, k);
      ak = ak & k;
    end
    if (n > 1)
    begin
      byte_io(d1, 1'b0, r, k);
      ak = ak & k;
    end
    stop();
  endtask : wr

  // Pointer set by a write, then repeated start and two-byte read
  task automatic rd(input logic [6:0] a, input logic [2:0] c,
                    output logic [7:0] q0, output logic [7:0] q1, output logic ak);
    logic k;
    logic j;
    start();
    byte_io({a, 1'b0}, 1'b0, q0, ak);
    byte_io({5'h00, c}, 1'b0, q0, k);
    start();
    byte_io({a, 1'b1}, 1'b0, q0, j);
    ak = ak & k & j;
    byte_io(8'hff, 1'b1, q0, k);
    byte_io(8'hff, 1'b0, q1, k);
    stop();
  endtask : rd
endmodule : gx_i2c_master
`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench for the serial GPIO expander
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import gx_pkg::*;
  typedef struct packed {
    logic [2:0] c;
    logic [1:0] n;
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] q0;
    logic [7:0] q1;
  } gx_row_s;
  logic       clk;
  logic       rst;
  logic [2:0] strap;
  gx_pair_s   pins;
  logic       sda_oe;
  logic       sda_out;
  logic       int_oe;
  logic       int_out;
  gx_pair_s   gp_out;
  gx_pair_s   gp_oe;
  logic       scl;
  logic       m_low;
  wire logic  sda_line;
  int         error_cnt;
  int         tests_run;
  logic [7:0] q0;
  logic [7:0] q1;
  logic       ak;
  gx_row_s    rows [7];

  // Pull-up: line high unless either party pulls it low
  assign sda_line = !((sda_oe && !sda_out) || m_low);

  gx_expander dut_u (.CLK(clk), .RST(rst), .SCL(scl), .SDA_IN(sda_line),
    .ADDR_STRAP(strap), .GPIO_IN(pins), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .INT_N_OUT(int_out), .INT_N_OE(int_oe), .GPIO_OUT(gp_out), .GPIO_OE(gp_oe));

  gx_i2c_master master_u (.clk(clk), .sda(sda_line), .scl(scl), .sda_low(m_low));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  task automatic wait_int(input logic exp);
    for (int i = 0; i < 20 && int_oe !== exp; i++)
      @(negedge clk);
    chk({14'h0000, int_oe, int_out}, {14'h0000, exp, 1'b0});
  endtask : wait_int

  initial
  begin
    repeat (60000) @(negedge clk);
    error_cnt++;
    wrap_up();
  end

  initial
  begin
    // Pins 16'h3c96 throughout; expected reads fold in the inversion
    rows = '{'{CMD_OUT0, 2'h2, 8'h5a, 8'ha5, 8'h5a, 8'ha5},
             '{CMD_POL1, 2'h1, 8'hf0, 8'h00, 8'hf0, 8'h00},
             '{CMD_POL0, 2'h1, 8'h0f, 8'h00, 8'h0f, 8'hf0},
             '{CMD_IN1,  2'h2, 8'h12, 8'h34, 8'hcc, 8'h99},
             '{CMD_CFG1, 2'h1, 8'h00, 8'h00, 8'h00, 8'hff},
             '{CMD_OUT1, 2'h0, 8'h00, 8'h00, 8'ha5, 8'h5a},
             '{CMD_IN0,  2'h0, 8'h00, 8'h00, 8'h99, 8'hcc}};
    error_cnt = 0;
    tests_run = 0;
    rst = 1'b1;
    strap = 3'h0;
    pins = 16'h3c96;
    repeat (10) @(negedge clk);
    chk(gp_oe, 16'h0000);
    chk(gp_out, OUT_RST);
    chk({14'h0000, sda_oe, int_oe}, 16'h0000);
    rst = 1'b0;
    repeat (20) @(negedge clk);
    chk({14'h0000, int_oe, int_out}, 16'h0000);
    foreach (rows[i])
    begin
      if (rows[i].n != 2'h0)
      begin
        master_u.wr({SLAVE_ADDR_HI, strap}, rows[i].c, rows[i].n, rows[i].b0, rows[i].b1, ak);
        chk({15'h0000, ak}, 16'h0001);
      end
      master_u.rd({SLAVE_ADDR_HI, strap}, rows[i].c, q0, q1, ak);
      chk({15'h0000, ak}, 16'h0001);
      chk({q1, q0}, {rows[i].q1, rows[i].q0});
    end
    chk(gp_oe, 16'hff00);
    chk(gp_out, 16'ha55a);
    wait_int(1'b0);
    pins.p0[0] = ~pins.p0[0];
    wait_int(1'b1);
    pins.p0[0] = ~pins.p0[0];
    wait_int(1'b0);
    pins.p0[7] = ~pins.p0[7];
    wait_int(1'b1);
    master_u.rd({SLAVE_ADDR_HI, strap}, CMD_IN0, q0, q1, ak);
    chk({q1, q0}, 16'hcc19);
    wait_int(1'b0);
    // Every strap setting: own address acked, complement refused
    for (int s = 0; s < 8; s++)
    begin
      strap = s[2:0];
      repeat (20) @(negedge clk);
      master_u.wr({SLAVE_ADDR_HI, strap}, CMD_IN0, 0, 8'h00, 8'h00, ak);
      chk({15'h0000, ak}, 16'h0001);
      master_u.wr({SLAVE_ADDR_HI, ~strap}, CMD_OUT0, 1, 8'h00, 8'h00, ak);
      chk({15'h0000, ak}, 16'h0000);
    end
    chk(gp_out, 16'ha55a);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    chk(gp_oe, 16'h0000);
    chk(gp_out, OUT_RST);
    rst = 1'b0;
    repeat (20) @(negedge clk);
    chk({14'h0000, int_oe, int_out}, 16'h0000);
    master_u.rd({SLAVE_ADDR_HI, strap}, CMD_CFG0, q0, q1, ak);
    chk({q1, q0}, CFG_RST);
    master_u.rd({SLAVE_ADDR_HI, strap}, CMD_POL0, q0, q1, ak);
    chk({q1, q0}, POL_RST);
    master_u.rd({SLAVE_ADDR_HI, strap}, CMD_OUT0, q0, q1, ak);
    chk({q1, q0}, OUT_RST);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
